// *** core/rps_pkg.sv ***
// Constants, types and helper functions for the resolver position source.
// Assumes one 200 MHz clock and a resolver-to-digital front end that delivers
// a 16-bit shaft angle synchronous to that clock.
//
// Summary of operation
// - Green indicator lit at power-up, stays lit unless a host initialization is rejected.
// - Red indicator lit at power-up, clears once initialized and no fault exists.
// - Red indicator stays lit on missing resolver or unsuitable resolution for speed.
// - Host selects 10, 12, 14 or 16 bits; position reported at that resolution.
// - Maximum shaft speed per mode is 14400, 3600, 900 or 225.
// - Speed above the mode maximum raises a fault; position may then be wrong.
package rps_pkg;

    localparam int ANGLE_W = 16;
    localparam logic [4:0] ANGLE_BITS = 5'h10;

    typedef enum logic [1:0] {
        RES_10 = 2'h0,
        RES_12 = 2'h1,
        RES_14 = 2'h2,
        RES_16 = 2'h3
    } rps_res_t;

    // Gray path: power-up -> running; a rejected init sits one code further on
    typedef enum logic [1:0] {
        ST_POWERUP = 2'h0,
        ST_RUN = 2'h1,
        ST_BADINIT = 2'h3
    } rps_state_t;

    localparam logic [4:0] RES_BITS_10 = 5'h0a;
    localparam logic [4:0] RES_BITS_12 = 5'h0c;
    localparam logic [4:0] RES_BITS_14 = 5'h0e;
    localparam logic [4:0] RES_BITS_16 = 5'h10;

    localparam int MAX_SPEED_10 = 32'h0000_3840;
    localparam int MAX_SPEED_12 = 32'h0000_0e10;
    localparam int MAX_SPEED_14 = 32'h0000_0384;
    localparam int MAX_SPEED_16 = 32'h0000_00e1;

    // The speed unit is taken as revolutions per minute
    localparam longint SPEED_UNIT_NS = 64'h0000_000d_f847_5800;
    localparam longint CLK_PERIOD_NS = 64'h0000_0000_0000_0005;
    localparam longint WINDOW_NS = 64'h0000_0000_000f_4240;
    localparam int WINDOW_CYCLES = int'(WINDOW_NS / CLK_PERIOD_NS);
    localparam longint REV_COUNTS = 64'h0000_0000_0001_0000;

    localparam logic [15:0] POS_RESET = 16'h0000;
    localparam logic [15:0] ANGLE_RESET = 16'h0000;
    localparam rps_res_t RES_RESET = RES_16;

    function automatic logic [4:0] res_bits(rps_res_t m);
        unique case (m)
            RES_10: return RES_BITS_10;
            RES_12: return RES_BITS_12;
            RES_14: return RES_BITS_14;
            RES_16: return RES_BITS_16;
        endcase
    endfunction

    function automatic int max_speed(rps_res_t m);
        unique case (m)
            RES_10: return MAX_SPEED_10;
            RES_12: return MAX_SPEED_12;
            RES_14: return MAX_SPEED_14;
            RES_16: return MAX_SPEED_16;
        endcase
    endfunction

    // Largest raw 16-bit angle change allowed in one measurement window
    function automatic logic [31:0] speed_limit(rps_res_t m, longint cycles);
        longint prod;
        prod = longint'(max_speed(m)) * REV_COUNTS * cycles * CLK_PERIOD_NS / SPEED_UNIT_NS;
        return prod[31:0];
    endfunction

    // Drop low angle bits so the count wraps at the selected counts per turn
    function automatic logic [15:0] scale_angle(logic [15:0] a, rps_res_t m);
        return a >> (ANGLE_BITS - res_bits(m));
    endfunction

endpackage

// *** core/rps_speed_monitor.sv ***
// Shaft speed monitor: compares angle travel per window with the mode limit.
// Assumes the shaft turns less than half a revolution per window, else the
// wrapped difference aliases and real overspeed can go unseen.
`timescale 1ns/1ps
module rps_speed_monitor #(
    parameter int WINDOW_CYCLES = rps_pkg::WINDOW_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Angle and mode
    input wire logic [15:0] angleRaw,
    input wire rps_pkg::rps_res_t resMode,
    // Result
    output logic overspeed
);
    logic [31:0] windowCount;
    logic [15:0] prevAngle;
    logic primed;
    wire windowEnd = (windowCount == 32'(WINDOW_CYCLES - 1));
    wire [15:0] delta = angleRaw - prevAngle;
    wire [15:0] magnitude = delta[15] ? 16'(-delta) : delta;
    wire [31:0] limit = rps_pkg::speed_limit(resMode, longint'(WINDOW_CYCLES));
    wire next_overspeed = primed && ({16'h0000, magnitude} > limit);

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            windowCount <= 32'h0000_0000;
            prevAngle <= rps_pkg::ANGLE_RESET;
            primed <= 1'b0;
            overspeed <= 1'b0;
        end else begin
            windowCount <= windowEnd ? 32'h0000_0000 : windowCount + 32'h0000_0001;
            if (windowEnd) begin
                prevAngle <= angleRaw;
                primed <= 1'b1;
                overspeed <= next_overspeed;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    speed_limit_check_a: assert property (
        windowEnd && primed |=> overspeed == ($past(magnitude) > $past(limit[15:0]))
            || $past(limit[31:16] != 16'h0000))
        else $error("overspeed does not match travel against mode limit");

    overspeed_hold_a: assert property (
        !windowEnd |=> $stable(overspeed))
        else $error("overspeed changed between window ends");
endmodule

// *** core/rps_position_source.sv ***
// Resolver position source top: host initialization, resolution select,
// scaled position output and the two status indicators.
// Assumes host strobes and resolver signals are synchronous to clk_sys.
`timescale 1ns/1ps
module rps_position_source #(
    parameter int WINDOW_CYCLES = rps_pkg::WINDOW_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Host controller
    input wire logic hostInitDone,
    input wire logic hostInitGood,
    input wire logic [1:0] hostResMode,
    output logic [15:0] position,
    output logic positionValid,
    // Resolver
    input wire logic [15:0] angleRaw,
    input wire logic resolverConnected,
    // Indicators
    output logic initIndicator,
    output logic fault_indicator,
    output logic overspeedFault
);
    rps_pkg::rps_state_t state;
    rps_pkg::rps_state_t next_state;
    rps_pkg::rps_res_t resMode;
    logic overspeed;

    wire initAccept = hostInitDone && hostInitGood;
    wire initReject = hostInitDone && !hostInitGood;
    wire rps_pkg::rps_res_t hostMode = rps_pkg::rps_res_t'(hostResMode);
    wire rps_pkg::rps_res_t next_resMode = hostInitDone ? hostMode : resMode;
    wire [15:0] next_position = rps_pkg::scale_angle(angleRaw, resMode);
    wire next_initIndicator = (next_state != rps_pkg::ST_BADINIT);
    // A fresh mode may need a window before overspeed reflects it; the
    // previous verdict is used meanwhile rather than hiding a fault.
    wire next_fault = (next_state != rps_pkg::ST_RUN) || !resolverConnected || overspeed;

    always_comb begin
        next_state = state;
        if (initAccept) begin
            next_state = rps_pkg::ST_RUN;
        end else if (initReject) begin
            next_state = rps_pkg::ST_BADINIT;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state <= rps_pkg::ST_POWERUP;
            resMode <= rps_pkg::RES_RESET;
        end else begin
            state <= next_state;
            resMode <= next_resMode;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            initIndicator <= 1'b1;
            fault_indicator <= 1'b1;
            overspeedFault <= 1'b0;
        end else begin
            initIndicator <= next_initIndicator;
            fault_indicator <= next_fault;
            overspeedFault <= overspeed;
        end
    end

    // Position keeps tracking even in overspeed; it is flagged, not frozen
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            position <= rps_pkg::POS_RESET;
            positionValid <= 1'b0;
        end else begin
            position <= next_position;
            positionValid <= (state == rps_pkg::ST_RUN);
        end
    end

    rps_speed_monitor #(
        .WINDOW_CYCLES(WINDOW_CYCLES)
    ) speedMonitor (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .angleRaw(angleRaw),
        .resMode(resMode),
        .overspeed(overspeed)
    );

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence initAccepted;
        hostInitDone && hostInitGood;
    endsequence

    sequence initRejected;
        hostInitDone && !hostInitGood;
    endsequence

    sequence cleanStart;
        initAccepted ##0 (resolverConnected && !overspeed);
    endsequence

    init_green_on_a: assert property (
        initAccepted |=> initIndicator && (state == rps_pkg::ST_RUN))
        else $error("green indicator not lit after accepted init");

    init_green_off_a: assert property (
        initRejected |=> !initIndicator ##1 (initIndicator == (state != rps_pkg::ST_BADINIT)))
        else $error("green indicator lit after rejected init");

    powerup_green_a: assert property (
        (state == rps_pkg::ST_POWERUP) && !hostInitDone |=> initIndicator)
        else $error("green indicator dark before any init");

    fault_until_init_a: assert property (
        (state == rps_pkg::ST_POWERUP) && !initAccept |=> fault_indicator)
        else $error("red indicator dark before init");

    fault_clears_a: assert property (
        cleanStart |=> !fault_indicator)
        else $error("red indicator lit after clean init");

    fault_disconnect_a: assert property (
        !resolverConnected |=> fault_indicator)
        else $error("red indicator dark with resolver missing");

    fault_overspeed_a: assert property (
        overspeed |=> fault_indicator && overspeedFault)
        else $error("red indicator dark during overspeed");

    mode_capture_a: assert property (
        hostInitDone |=> resMode == $past(hostMode) ##1 $stable(resMode) || $past(hostInitDone))
        else $error("resolution mode not captured at init");

    position_scale_a: assert property (
        ##1 position == ($past(angleRaw) >> (rps_pkg::ANGLE_BITS - rps_pkg::res_bits($past(resMode)))))
        else $error("position not at selected resolution");

    position_wrap_a: assert property (
        ##1 (({16'h0000, position} >> rps_pkg::res_bits($past(resMode))) == 32'h0000_0000))
        else $error("position exceeds counts per revolution");

    // Steady-state checks hold only while no host strobe changes the state
    sequence runSteady;
        state == rps_pkg::ST_RUN && !initReject;
    endsequence

    sequence badSteady;
        state == rps_pkg::ST_BADINIT && !initAccept;
    endsequence

    green_run_a: assert property (
        runSteady |=> initIndicator)
        else $error("green indicator dark while running");

    green_bad_a: assert property (
        badSteady |=> !initIndicator)
        else $error("green indicator lit after failed init");

    green_state_a: assert property (
        ##1 initIndicator == (state != rps_pkg::ST_BADINIT))
        else $error("green indicator disagrees with init state");

    powerup_hold_a: assert property (
        state == rps_pkg::ST_POWERUP && !hostInitDone |=> state == rps_pkg::ST_POWERUP)
        else $error("left power-up state without host init");

    state_legal_a: assert property (
        state inside {rps_pkg::ST_POWERUP, rps_pkg::ST_RUN, rps_pkg::ST_BADINIT})
        else $error("init state holds an unused code");

    fault_bad_a: assert property (
        badSteady |=> fault_indicator)
        else $error("red indicator dark after failed init");

    fault_reject_a: assert property (
        initRejected |=> fault_indicator)
        else $error("red indicator dark after rejected init");

    fault_run_clear_a: assert property (
        runSteady ##0 (resolverConnected && !overspeed) |=> !fault_indicator)
        else $error("red indicator lit with no fault while running");

    fault_cause_a: assert property (
        ##1 !fault_indicator |-> ($past(resolverConnected) && !$past(overspeed)))
        else $error("red indicator dark while a fault was present");

    valid_rise_a: assert property (
        initAccepted |=> ##1 positionValid)
        else $error("position not valid after accepted init");

    valid_drop_a: assert property (
        initRejected |=> ##1 !positionValid)
        else $error("position valid after rejected init");

    valid_state_a: assert property (
        ##1 positionValid == ($past(state) == rps_pkg::ST_RUN))
        else $error("position valid disagrees with run state");

    mode_hold_a: assert property (
        !hostInitDone |=> $stable(resMode))
        else $error("resolution changed without host init");

    mode_full_a: assert property (
        resMode == rps_pkg::RES_16 |=> position == $past(angleRaw))
        else $error("16-bit position differs from shaft angle");

    mode_ten_a: assert property (
        resMode == rps_pkg::RES_10 |=> position == {6'h00, $past(angleRaw[15:6])})
        else $error("10-bit position differs from top angle bits");

    position_zero_a: assert property (
        angleRaw == 16'h0000 |=> position == 16'h0000)
        else $error("position not zero at zero angle");

    overspeed_copy_a: assert property (
        ##1 overspeedFault == $past(overspeed))
        else $error("overspeed flag does not follow the monitor");

    overspeed_clear_a: assert property (
        !overspeed |=> !overspeedFault)
        else $error("overspeed flag lit without overspeed");
endmodule

// *** core/_unused_placeholder_do_not_compile.sv ***
// Intentionally empty.

// *** testbench/rps_resolver_model.sv ***
// Behavioural resolver sensor: shaft angle that turns at a set step rate.
// Assumes the bench drives its controls just after the rising clock edge.
`timescale 1ns/1ps
module rps_resolver_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Motion control
    input wire logic [7:0] stepDiv,
    input wire logic loadEn,
    input wire logic [15:0] loadVal,
    input wire logic plugged,
    // Sensor side
    output logic [15:0] angleRaw,
    output logic resolverConnected
);
    logic [15:0] angle;
    logic [7:0] divCount;
    logic [15:0] noise;

    // One count every stepDiv cycles; zero holds the shaft still
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            angle <= 16'h0000;
            divCount <= 8'h00;
            noise <= 16'h5a5a;
        end else begin
            noise <= ~{noise[14:0], noise[15]};
            if (loadEn) begin
                angle <= loadVal;
            end else if (stepDiv != 8'h00) begin
                if (divCount >= stepDiv - 8'h01) begin
                    divCount <= 8'h00;
                    angle <= angle + 16'h0001;
                end else begin
                    divCount <= divCount + 8'h01;
                end
            end
        end
    end

    // Unplugged lines float: show a changing pattern, never the last angle
    assign angleRaw = plugged ? angle : noise;
    assign resolverConnected = plugged;
endmodule

// *** testbench/rps_position_source_tb.sv ***
// Self-checking bench for the resolver position source.
// Assumes a short speed window of 200 cycles so overspeed shows quickly.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin testsRun++; if ((got) !== (exp)) begin badCount++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module rps_position_source_tb;
    localparam int WIN = 200;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic hostInitDone = 1'b0;
    logic hostInitGood = 1'b0;
    logic [1:0] hostResMode = 2'h3;
    logic [15:0] position, angleRaw, loadVal = 16'h0000, a;
    logic positionValid, resolverConnected, initIndicator, fault_indicator, overspeedFault;
    logic [7:0] stepDiv = 8'h00;
    logic loadEn = 1'b0;
    logic plugged = 1'b1;
    int badCount = 0;
    int testsRun = 0;
    int bitsOf[4] = '{10, 12, 14, 16};

    always #2.5 clk_sys = ~clk_sys;

    rps_position_source #(.WINDOW_CYCLES(WIN)) rps_position_source_i (.clk_sys(clk_sys),
        .reset_n(reset_n), .hostInitDone(hostInitDone), .hostInitGood(hostInitGood),
        .hostResMode(hostResMode), .position(position), .positionValid(positionValid),
        .angleRaw(angleRaw), .resolverConnected(resolverConnected),
        .initIndicator(initIndicator), .fault_indicator(fault_indicator),
        .overspeedFault(overspeedFault));
    rps_resolver_model rps_resolver_model_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .stepDiv(stepDiv), .loadEn(loadEn), .loadVal(loadVal), .plugged(plugged),
        .angleRaw(angleRaw), .resolverConnected(resolverConnected));

    function automatic logic [15:0] exp_pos(logic [15:0] ang, int bits);
        return ang >> (16 - bits);
    endfunction

    task automatic cyc(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic host_init(logic good, logic [1:0] mode);
        hostInitDone = 1'b1;
        hostInitGood = good;
        hostResMode = mode;
        cyc(1);
        hostInitDone = 1'b0;
    endtask

    task automatic load_angle(logic [15:0] v);
        loadEn = 1'b1;
        loadVal = v;
        cyc(1);
        loadEn = 1'b0;
        cyc(3);
    endtask

    task automatic closeOut();
        $display("checks %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #(20000 * 5);
        badCount++;
        closeOut();
    end

    initial begin
        void'($urandom(3));
        cyc(20);
        `CHK("init led at reset", 1'b1, initIndicator)
        `CHK("fault led at reset", 1'b1, fault_indicator)
        reset_n = 1'b1;
        cyc(1);
        `CHK("fault led before init", 1'b1, fault_indicator)
        // Every mode: random angle, top count and wrap back to zero
        for (int m = 0; m < 4; m++) begin
            host_init(1'b1, 2'(m));
            a = 16'($urandom);
            load_angle(a);
            `CHK("valid", 1'b1, positionValid)
            `CHK("position", exp_pos(a, bitsOf[m]), position)
            load_angle(16'hffff);
            `CHK("top count", 16'((32'h1 << bitsOf[m]) - 1), position)
            load_angle(16'h0000);
            `CHK("wrapped", 16'h0000, position)
            cyc(3 * WIN);
            `CHK("init led on", 1'b1, initIndicator)
            `CHK("fault led off", 1'b0, fault_indicator)
            $display("test mode %0d done", m);
        end
        // Resolver unplugged then restored
        plugged = 1'b0;
        cyc(3);
        `CHK("fault unplugged", 1'b1, fault_indicator)
        plugged = 1'b1;
        cyc(3 * WIN);
        `CHK("fault replugged", 1'b0, fault_indicator)
        $display("test connection done");
        // Ten counts per window: inside the 10-bit limit, over the 12-bit one
        host_init(1'b1, 2'h0);
        stepDiv = 8'd20;
        cyc(4 * WIN);
        `CHK("no overspeed 10 bit", 1'b0, overspeedFault)
        `CHK("fault 10 bit", 1'b0, fault_indicator)
        host_init(1'b1, 2'h1);
        cyc(2 * WIN + 3);
        `CHK("overspeed 12 bit", 1'b1, overspeedFault)
        `CHK("fault 12 bit", 1'b1, fault_indicator)
        stepDiv = 8'h00;
        cyc(3 * WIN);
        `CHK("overspeed cleared", 1'b0, overspeedFault)
        $display("test overspeed done");
        // Rejected init, then a good one
        host_init(1'b0, 2'h2);
        cyc(3);
        `CHK("init led bad", 1'b0, initIndicator)
        `CHK("fault led bad", 1'b1, fault_indicator)
        host_init(1'b1, 2'h2);
        cyc(3);
        `CHK("init led good", 1'b1, initIndicator)
        `CHK("fault led good", 1'b0, fault_indicator)
        $display("test reinit done");
        closeOut();
    end
endmodule
